/* File: shared/bwio_pkg.sv */
/*
 * bwio_pkg: constants shared by the byte-wide port and its FIFO.
 * assumes a single 125 MHz clock domain.
 */
package bwio_pkg;
    localparam int         DATA_W        = 8;
    localparam int         FIFO_DEPTH    = 32;
    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam logic       MODE_INPUT    = 1'b0;
    localparam logic       MODE_OUTPUT   = 1'b1;
    localparam int         SYNC_STAGES   = 2;
    localparam int         CLK_PERIOD_NS = 8;
    typedef enum logic [1:0] {
        BWIO_IDLE,
        BWIO_OPEN,
        BWIO_HELD
    } bwio_strobe_t;
endpackage

/* File: rtl/bwio_fifo.sv */
/*
 * bwio_fifo: synchronous FIFO with valid/ready on both sides.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module bwio_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic             doWr;
    logic             doRd;

    assign inReady  = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign doWr     = inValid && inReady;
    assign doRd     = outValid && outReady;
    assign outData  = mem[rdPtr_q];

    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (doWr) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (doRd) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            if (doWr && !doRd) begin
                count_q <= count_q + 1'b1;
            end else if (doRd && !doWr) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

/* File: rtl/bwio_port.sv */
/*
 * bwio_port: byte-wide mode-programmable parallel port with a
 * service-request flip-flop, modelled synchronously to clk.
 * assumes all pins are asynchronous to clk; the mode pin is static.
 */
//
// Function
// R1 - the mode pin selects input behaviour when low and output when high.
// R2 - in input mode the register follows port_in_byte while strobe is high.
// R3 - in input mode strobe falling freezes the byte and asserts the request.
// R4 - in input mode both selects high drive the register onto the outputs.
// R5 - in input mode either select low floats outputs and drops the request; the code drops it only on the deselect edge, and a same-cycle strobe fall wins.
// R6 - in output mode the outputs are driven at all times.
// R7 - in output mode the register follows input while selected and strobe high.
// R8 - in output mode strobe falling while selected holds the byte.
// R9 - in output mode deselect raises the request, next strobe fall drops it.
// R10 - clear zeroes the register and resets the request flip-flop.
// R11 - first select and request invert their polarity with the mode.
// R12 - clear overrides strobe activity and strobe edges are sampled on clk.
`timescale 1ns/1ps
module bwio_port (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       portMode,
    input  wire logic       strobeClk,
    input  wire logic       clear_b,
    input  wire logic       select_first,
    input  wire logic       select_second,
    input  wire logic [7:0] port_in_byte,
    output logic      [7:0] port_out_byte,
    output logic            portOutEnable,
    output logic            service_request_flag,
    output logic      [7:0] capData,
    output logic            capValid,
    input  wire logic       capReady,
    output logic            capOverrun
);
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [11:0] meta_q;
    logic [11:0] sync_q;
    logic [11:0] pinsRaw;

    assign pinsRaw = {port_in_byte, portMode, strobeClk,
                      select_first, select_second};

    always_ff @(posedge clk) begin
        meta_q <= pinsRaw;
        sync_q <= meta_q;
    end

    // clear is synchronised too; its effect is immediate once seen
    logic clrMeta_q;
    logic clrSync_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clrMeta_q <= 1'b1;
            clrSync_q <= 1'b1;
        end else begin
            clrMeta_q <= clear_b;
            clrSync_q <= clrMeta_q;
        end
    end

    logic [7:0] dataIn;
    logic       modeOut;
    logic       strobe;
    logic       selA;
    logic       selB;
    assign dataIn  = sync_q[11:4];
    assign modeOut = (sync_q[3] == bwio_pkg::MODE_OUTPUT); // R1
    assign strobe  = sync_q[2];
    assign selA    = sync_q[1];
    assign selB    = sync_q[0];

    // ---------------------------------------------------------------
    // selection and strobe edge
    // ---------------------------------------------------------------
    logic selected;
    logic strobePrev_q;
    logic strobeFall;
    logic clearing;

    // first select flips sense with the mode
    assign selected = modeOut ? (!selA && selB) : (selA && selB); // R11
    assign clearing = !rst_b || !clrSync_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            strobePrev_q <= 1'b0;
        end else begin
            strobePrev_q <= strobe;
        end
    end
    assign strobeFall = strobePrev_q && !strobe; // R12

    // ---------------------------------------------------------------
    // data register
    // ---------------------------------------------------------------
    logic [7:0] dataReg_q;
    logic       loadOpen;

    // input mode ignores selects for capture; output mode needs them
    assign loadOpen = strobe && (!modeOut || selected); // R2 R7 R8

    always_ff @(posedge clk) begin
        if (clearing) begin
            dataReg_q <= bwio_pkg::REG_RESET; // R10 R12
        end else if (loadOpen) begin
            dataReg_q <= dataIn; // R2 R7
        end
    end
    // once strobe falls the register simply stops loading: R3 R8

    // ---------------------------------------------------------------
    // service request flip-flop (stored active-high as "pending")
    // ---------------------------------------------------------------
    logic reqPend_q;
    logic selPrev_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            selPrev_q <= 1'b0;
        end else begin
            selPrev_q <= selected;
        end
    end

    always_ff @(posedge clk) begin
        if (clearing) begin
            reqPend_q <= 1'b0; // R10
        end else if (!modeOut) begin
            // a new byte wins over a simultaneous deselect
            if (strobeFall) begin
                reqPend_q <= 1'b1; // R3
            end else if (selPrev_q && !selected) begin
                // only the end of a read drops it; idle deselect keeps it
                reqPend_q <= 1'b0; // R5
            end
        end else begin
            if (selPrev_q && !selected) begin
                reqPend_q <= 1'b1; // R9
            end else if (strobeFall) begin
                reqPend_q <= 1'b0; // R9
            end
        end
    end

    // ---------------------------------------------------------------
    // pin outputs
    // ---------------------------------------------------------------
    logic [7:0] outByte_q;
    logic       outEn_q;
    logic       srPin_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            outByte_q <= bwio_pkg::REG_RESET;
            outEn_q   <= 1'b0;
            srPin_q   <= 1'b1;
        end else begin
            outByte_q <= dataReg_q;
            outEn_q   <= modeOut || selected; // R4 R5 R6
            // input mode: low means pending; output mode: high means pending
            srPin_q   <= modeOut ? reqPend_q : !reqPend_q; // R11 R10
        end
    end

    assign port_out_byte        = outByte_q;
    assign portOutEnable        = outEn_q;
    assign service_request_flag = srPin_q;

    // ---------------------------------------------------------------
    // capture stream: each byte held by a strobe fall is queued for the local side if the FIFO has room
    // ---------------------------------------------------------------
    logic       fifoInReady;
    logic       pushPend_q;
    logic       ovr_q;

    // push one cycle after the strobe fall so the held byte is used
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pushPend_q <= 1'b0;
        end else begin
            pushPend_q <= strobeFall && !clearing &&
                          (!modeOut || selected);
        end
    end

    // a full FIFO cannot stall the peripheral, so losses are flagged
    always_ff @(posedge clk) begin
        if (clearing) begin
            ovr_q <= 1'b0;
        end else if (pushPend_q && !fifoInReady) begin
            ovr_q <= 1'b1;
        end
    end
    assign capOverrun = ovr_q;

    bwio_fifo #(
        .WIDTH (bwio_pkg::DATA_W),
        .DEPTH (bwio_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst_b    (rst_b),
        .inData   (dataReg_q),
        .inValid  (pushPend_q),
        .inReady  (fifoInReady),
        .outData  (capData),
        .outValid (capValid),
        .outReady (capReady)
    );
endmodule

/* File: verif/bwio_port_asserts.sv */
/* bwio_port_asserts: pin-level checks on bwio_port.
   assumes pins held >=3 clocks, so 6 clocks covers sync and output. */
`timescale 1ns/1ps
module bwio_port_asserts (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       portMode,
    input wire logic       strobeClk,
    input wire logic       clear_b,
    input wire logic       select_first,
    input wire logic       select_second,
    input wire logic [7:0] port_in_byte,
    input wire logic [7:0] port_out_byte,
    input wire logic       portOutEnable,
    input wire logic       service_request_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    out_drive_a: assert property (
        portMode[*6] |-> portOutEnable) else $error("not driving");
    in_float_a: assert property (
        (!portMode && !(select_first && select_second))[*6]
        |-> !portOutEnable) else $error("not floated");
    in_sel_a: assert property (
        (!portMode && select_first && select_second)[*6]
        |-> portOutEnable) else $error("not enabled");
    clr_out_a: assert property (
        (!clear_b && portMode)[*6]
        |-> port_out_byte == 8'h00 && !service_request_flag)
        else $error("clear failed in output mode");
    clr_in_a: assert property (
        (!clear_b && !portMode)[*6] |-> service_request_flag)
        else $error("clear failed in input mode");
    // deselect wins a tie with a strobe fall, so a fall before it is safe
    desel_req_a: assert property (
        (portMode && !select_first && select_second) ##1
        (portMode && (select_first || !select_second) && !strobeClk
        && clear_b)[*6] |-> service_request_flag)
        else $error("request not raised");
    fall_req_a: assert property (
        (!portMode && strobeClk)[*3] ##1 (!portMode && !strobeClk &&
        clear_b && $stable({select_first, select_second}))[*6]
        |-> !service_request_flag) else $error("request not low");
    pass_thru_a: assert property (
        (portMode && !select_first && select_second && strobeClk &&
        clear_b && $stable(port_in_byte))[*6]
        |-> port_out_byte == port_in_byte) else $error("not transparent");
endmodule
bind bwio_port bwio_port_asserts bwio_port_asserts_i (.clk(clk),
    .rst_b(rst_b), .portMode(portMode), .strobeClk(strobeClk),
    .clear_b(clear_b), .select_first(select_first),
    .select_second(select_second), .port_in_byte(port_in_byte),
    .port_out_byte(port_out_byte), .portOutEnable(portOutEnable),
    .service_request_flag(service_request_flag));

/* File: verif/bwio_periph_model.sv */
/* bwio_periph_model: far-side agent owning strobe and data pins.
   assumes the bench calls strobeByte from its negedge-driven flow. */
`timescale 1ns/1ps
module bwio_periph_model (
    input  wire logic       clk,
    output logic            strobeClk,
    output logic      [7:0] port_in_byte
);
    initial begin
        strobeClk = 1'b0;
        port_in_byte = 8'h00;
    end
    // strobe idles low; stale data is inverted after the hold so a
    // late capture cannot match by luck
    task automatic strobeByte(input logic [7:0] b);
        @(negedge clk);
        port_in_byte = b;
        @(negedge clk);
        strobeClk = 1'b1;
        repeat (6) @(negedge clk);
        strobeClk = 1'b0;
        repeat (2) @(negedge clk);
        port_in_byte = ~b;
        repeat (4) @(negedge clk);
    endtask
endmodule

/* File: verif/byte_wide_io_port_tb.sv */
/* byte_wide_io_port_tb: self-checking bench for bwio_port.
   assumes the peripheral model owns the strobe and data pins. */
`timescale 1ns/1ps
module byte_wide_io_port_tb;
    logic        clk = 1'b0;
    logic        rst_b, portMode, strobeClk, clear_b, capValid, capReady;
    logic        select_first, select_second, portOutEnable, capOverrun;
    logic        service_request_flag, m, xe;
    logic [7:0]  port_in_byte, port_out_byte, capData, d, xo;
    int          miscompares = 0;
    int          samplesChecked = 0;
    // mode, data in, expected data out, enable after deselect
    logic [17:0] rows [4] = '{{1'b0, 8'hA5, 8'hA5, 1'b0},
        {1'b0, 8'h3C, 8'h3C, 1'b0}, {1'b1, 8'h5A, 8'h5A, 1'b1},
        {1'b1, 8'hFF, 8'hFF, 1'b1}};
    always #4 clk = ~clk;
    bwio_port bwio_port_i (.clk(clk), .rst_b(rst_b), .portMode(portMode),
        .strobeClk(strobeClk), .clear_b(clear_b),
        .select_first(select_first), .select_second(select_second),
        .port_in_byte(port_in_byte), .port_out_byte(port_out_byte),
        .portOutEnable(portOutEnable), .capOverrun(capOverrun),
        .service_request_flag(service_request_flag), .capData(capData),
        .capValid(capValid), .capReady(capReady));
    bwio_periph_model bwio_periph_model_i (.clk(clk),
        .strobeClk(strobeClk), .port_in_byte(port_in_byte));
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // bounded wait for the head byte, then pop it with a one-cycle ready
    task automatic capChk(input logic [7:0] exp);
        int n;
        for (n = 0; n < 20 && capValid !== 1'b1; n++)
            @(negedge clk);
        if (n == 20) begin
            miscompares++;
            tally_and_finish();
        end else begin
            chk(capData, exp);
            capReady = 1'b1;
            wt(1);
            capReady = 1'b0;
        end
    endtask
    initial begin
        {rst_b, portMode, clear_b, capReady} = 4'h2;
        {select_first, select_second} = 2'h0;
        wt(10);
        rst_b = 1'b1;
        wt(1);
        chk({4'h0, portOutEnable, service_request_flag, capValid,
            capOverrun}, 8'h04);
        $display("reset end");
        for (int i = 0; i < 4; i++) begin
            {m, d, xo, xe} = rows[i];
            portMode = m;
            {select_first, select_second} = {~m, 1'b1};
            wt(8);
            bwio_periph_model_i.strobeByte(d);
            wt(8);
            chk(port_out_byte, xo);
            chk({6'h00, portOutEnable, service_request_flag},
                8'h02);
            capChk(d);
            select_second = 1'b0;
            wt(8);
            chk({6'h00, portOutEnable, service_request_flag},
                {6'h00, xe, 1'b1});
            $display("row %0d end", i);
        end
        bwio_periph_model_i.strobeByte(8'h11);
        wt(8);
        chk(port_out_byte, 8'hFF);
        chk({6'h00, service_request_flag, capValid}, 8'h00);
        clear_b = 1'b0;
        wt(6);
        chk(port_out_byte | {7'h00, service_request_flag}, 8'h00);
        $display("deselected strobe and clear end");
        clear_b = 1'b1;
        portMode = 1'b0;
        wt(8);
        for (int j = 0; j < 33; j++)
            bwio_periph_model_i.strobeByte(8'(j));
        wt(8);
        chk({5'h00, service_request_flag, capOverrun, capValid},
            8'h03);
        for (int j = 0; j < 32; j++)
            capChk(8'(j));
        chk({7'h00, capValid}, 8'h00);
        clear_b = 1'b0;
        wt(6);
        chk({6'h00, service_request_flag, capOverrun}, 8'h02);
        bwio_periph_model_i.strobeByte(8'h77);
        chk(port_out_byte, 8'h00);
        chk({6'h00, service_request_flag, capValid}, 8'h02);
        $display("overrun and input clear end");
        clear_b = 1'b1;
        rst_b = 1'b0;
        wt(4);
        rst_b = 1'b1;
        wt(1);
        chk({4'h0, portOutEnable, service_request_flag, capValid,
            capOverrun}, 8'h04);
        $display("mid-run reset end");
        tally_and_finish();
    end
endmodule
